/* File: hdl/iox_pkg.sv */
/*
 * iox_pkg: shared constants of the two-wire I/O expander register block.
 * Holds the slave address layout, the command selector codes, the reset
 * values of the writable registers and the bus state encoding.
 * Assumes every user writes iox_pkg::name and imports nothing.
 */
package iox_pkg;

    // width of one I/O port and of every register byte
    localparam int          IOX_PORT_W      = 8;
    // synchroniser depth for everything arriving from the pins
    localparam int          IOX_SYNC_STAGES = 2;
    // reset levels of {scl, sda, strap low, strap high}: bus lines idle high,
    // so the edge detectors see no false edge when reset lets go
    localparam logic [3:0]  IOX_BUS_SYNC_RST = 4'hc;

    // upper five bits of the 7-bit slave address, straps fill the low two
    localparam logic [4:0]  IOX_ADDR_FIXED  = 5'h1d;
    // position of the direction bit in the address byte (1 = read)
    localparam int          IOX_RW_BIT      = 0;

    // command selector codes (low three bits of the control register)
    localparam logic [2:0]  IOX_REG_IN0     = 3'h0;
    localparam logic [2:0]  IOX_REG_IN1     = 3'h1;
    localparam logic [2:0]  IOX_REG_OUT0    = 3'h2;
    localparam logic [2:0]  IOX_REG_OUT1    = 3'h3;
    localparam logic [2:0]  IOX_REG_INV0    = 3'h4;
    localparam logic [2:0]  IOX_REG_INV1    = 3'h5;
    localparam logic [2:0]  IOX_REG_DIR0    = 3'h6;
    localparam logic [2:0]  IOX_REG_DIR1    = 3'h7;

    // register kinds, selected by command bits 2:1
    localparam logic [1:0]  IOX_KIND_IN     = 2'h0;
    localparam logic [1:0]  IOX_KIND_OUT    = 2'h1;
    localparam logic [1:0]  IOX_KIND_INV    = 2'h2;
    localparam logic [1:0]  IOX_KIND_DIR    = 2'h3;

    // reset values
    localparam logic [7:0]  IOX_OUT_RST     = 8'hff;
    localparam logic [7:0]  IOX_INV_RST     = 8'h00;
    localparam logic [7:0]  IOX_DIR_RST     = 8'hff;
    localparam logic [7:0]  IOX_CMD_RST     = 8'h00;

    // bits per byte on the wire
    localparam logic [3:0]  IOX_BITS_BYTE   = 4'h8;

    // bus engine states, gray coded along the write and read paths
    typedef enum logic [3:0] {
        IOX_ST_IDLE   = 4'h0,
        IOX_ST_ADDR   = 4'h1,
        IOX_ST_AACK   = 4'h3,
        IOX_ST_CMD    = 4'h2,
        IOX_ST_CACK   = 4'h6,
        IOX_ST_WDATA  = 4'h7,
        IOX_ST_WACK   = 4'h5,
        IOX_ST_RDATA  = 4'hb,
        IOX_ST_RACK   = 4'ha
    } iox_state_t;

endpackage

/* File: hdl/iox_sync.sv */
/*
 * iox_sync: two-flop synchroniser for a bundle of asynchronous levels.
 * Assumes each bit is an independent level; multi-bit words are not
 * guaranteed coherent, which is fine for pins and straps.
 */
`timescale 1ns/10ps
module iox_sync #(
    parameter int           W       = 1,
    // level held through reset, best set to the idle level of each line
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         i_mclk,
    input  wire logic         i_nrst,
    // asynchronous input and synchronised output
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta_q;   // first stage, read only by the second
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;   // second stage, safe to use
    logic [W-1:0] sync_d;

    // next values: plain shift through two stages
    always_comb begin
        meta_d = i_d;
        sync_d = meta_q;
    end

    // registers, preset to RST_VAL by the synchronous reset
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_q = sync_q;

endmodule

/* File: hdl/iox_expander.sv */
/*
 * iox_expander: two-wire slave and register file of a 16-bit I/O expander.
 * Decodes the strapped slave address, keeps the command byte and the
 * output, inversion and direction registers, and drives the two ports.
 * Assumes the bus clock is far slower than i_mclk (oversampled), that
 * the serial data line is open drain with an external pull-up, and
 * that the testbench resolves pins from the output enables.
 */
`timescale 1ns/10ps

module iox_expander #(
    parameter int PORT_W = iox_pkg::IOX_PORT_W
) (
    // clock and synchronous active-low reset (also the reset pin)
    input  wire logic              i_mclk,
    input  wire logic              i_nrst,
    // address straps
    input  wire logic              i_addr_strap_low,
    input  wire logic              i_addr_strap_high,
    // two-wire bus: clock in, open-drain data
    input  wire logic              i_scl,
    input  wire logic              i_sda,
    output logic                   o_sda,
    output logic                   o_sda_oe,
    // port zero pins
    input  wire logic [PORT_W-1:0] i_port_zero_pins,
    output logic      [PORT_W-1:0] o_port_zero_pins,
    output logic      [PORT_W-1:0] o_port_zero_oe,
    // port one pins
    input  wire logic [PORT_W-1:0] i_port_one_pins,
    output logic      [PORT_W-1:0] o_port_one_pins,
    output logic      [PORT_W-1:0] o_port_one_oe
);

    // the engine shifts whole bytes, so ports must be one byte wide
    if (PORT_W != 8) begin : g_width_check
        $error("iox_expander: PORT_W must be 8");
    end

    // synchronised pins and straps
    logic                  scl_s;       // bus clock level
    logic                  sda_s;       // bus data level
    logic                  strap_lo_s;  // low address strap
    logic                  strap_hi_s;  // high address strap
    logic [7:0]            pin0_s;      // port zero levels
    logic [7:0]            pin1_s;      // port one levels

    // edge history of the bus lines
    logic                  scl_prev_q;
    logic                  scl_prev_d;
    logic                  sda_prev_q;
    logic                  sda_prev_d;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  bus_start;   // also covers a repeated start
    logic                  bus_stop;

    // bus engine state
    iox_pkg::iox_state_t   st_q;
    iox_pkg::iox_state_t   st_d;
    logic [3:0]            cnt_q;       // bits seen in the current byte
    logic [3:0]            cnt_d;
    logic [7:0]            sh_q;        // receive shift register
    logic [7:0]            sh_d;
    logic [7:0]            tx_q;        // transmit shift register
    logic [7:0]            tx_d;
    logic                  rw_q;        // direction of this transaction
    logic                  rw_d;
    logic                  mnack_q;     // master answer after a read byte
    logic                  mnack_d;
    logic                  sda_oe_q;    // pull data low while set
    logic                  sda_oe_d;
    // control register and register file
    logic [7:0]            cmd_q;
    logic [7:0]            cmd_d;
    logic [1:0][7:0]       lat_q;       // output latches
    logic [1:0][7:0]       lat_d;
    logic [1:0][7:0]       inv_q;       // polarity inversion
    logic [1:0][7:0]       inv_d;
    logic [1:0][7:0]       dir_q;       // direction, 1 = input
    logic [1:0][7:0]       dir_d;
    logic [1:0][7:0]       poe_q;       // registered pin enables
    logic [1:0][7:0]       poe_d;
    // helpers
    logic [6:0]            own_addr;
    logic [2:0]            next_sel;    // other register of the pair
    logic [7:0]            rd_cur;      // read value for cmd_q
    logic [7:0]            rd_next;     // read value for next_sel

    // all outside levels pass two flops; the bus lines reset to idle high
    iox_sync #(.W (4), .RST_VAL (iox_pkg::IOX_BUS_SYNC_RST)) u_sync_bus (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_d    ({i_scl, i_sda, i_addr_strap_low, i_addr_strap_high}),
        .o_q    ({scl_s, sda_s, strap_lo_s, strap_hi_s})
    );

    iox_sync #(.W (16)) u_sync_pins (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_d    ({i_port_one_pins, i_port_zero_pins}),
        .o_q    ({pin1_s, pin0_s})
    );

    // read mux: input kind shows live pins through the inversion mask
    function automatic logic [7:0] rd_val(input logic [2:0] sel);
        logic [7:0] v;
        v = '0;
        case (sel[2:1])
            iox_pkg::IOX_KIND_IN:
                v = (sel[0] ? pin1_s : pin0_s) ^ inv_q[sel[0]];
            iox_pkg::IOX_KIND_OUT: v = lat_q[sel[0]];
            iox_pkg::IOX_KIND_INV: v = inv_q[sel[0]];
            iox_pkg::IOX_KIND_DIR: v = dir_q[sel[0]];
            default:               v = '0;
        endcase
        return v;
    endfunction

    // strapped address and edge detection on the sampled bus
    always_comb begin
        own_addr   = {iox_pkg::IOX_ADDR_FIXED, strap_hi_s, strap_lo_s};
        scl_prev_d = scl_s;
        sda_prev_d = sda_s;
        scl_rise   = scl_s & ~scl_prev_q;
        scl_fall   = ~scl_s & scl_prev_q;
        // data moving while the clock is high marks start or stop
        bus_start  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
        bus_stop   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
        next_sel   = {cmd_q[2:1], ~cmd_q[0]};
        rd_cur     = rd_val(cmd_q[2:0]);
        rd_next    = rd_val(next_sel);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_prev_d;
            sda_prev_q <= sda_prev_d;
        end
    end

    // bus engine and register writes: one next-state process
    always_comb begin
        st_d     = st_q;
        cnt_d    = cnt_q;
        sh_d     = sh_q;
        tx_d     = tx_q;
        rw_d     = rw_q;
        mnack_d  = mnack_q;
        sda_oe_d = sda_oe_q;
        cmd_d    = cmd_q;
        lat_d    = lat_q;
        inv_d    = inv_q;
        dir_d    = dir_q;
        if (bus_start) begin
            // start or repeated start: listen for an address byte
            st_d     = iox_pkg::IOX_ST_ADDR;
            cnt_d    = '0;
            sda_oe_d = 1'b0;
        end else if (bus_stop) begin
            // stop always frees the data line
            st_d     = iox_pkg::IOX_ST_IDLE;
            sda_oe_d = 1'b0;
        end else begin
            case (st_q)
                iox_pkg::IOX_ST_ADDR,
                iox_pkg::IOX_ST_CMD,
                iox_pkg::IOX_ST_WDATA: begin
                    // receive: sample on the rising clock edge
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == iox_pkg::IOX_BITS_BYTE) begin
                        cnt_d = '0;
                        if (st_q == iox_pkg::IOX_ST_ADDR) begin
                            if (sh_q[7:1] == own_addr) begin
                                rw_d     = sh_q[iox_pkg::IOX_RW_BIT];
                                sda_oe_d = 1'b1;
                                st_d     = iox_pkg::IOX_ST_AACK;
                            end else begin
                                // not ours: no ack, sleep until next start
                                st_d = iox_pkg::IOX_ST_IDLE;
                            end
                        end else if (st_q == iox_pkg::IOX_ST_CMD) begin
                            cmd_d    = sh_q;
                            sda_oe_d = 1'b1;
                            st_d     = iox_pkg::IOX_ST_CACK;
                        end else begin
                            sda_oe_d = 1'b1;
                            st_d     = iox_pkg::IOX_ST_WACK;
                        end
                    end
                end
                iox_pkg::IOX_ST_AACK: begin
                    // end of address ack: branch on direction
                    if (scl_fall) begin
                        cnt_d = '0;
                        if (rw_q) begin
                            // read uses the stored selection, no command
                            tx_d     = rd_cur;
                            sda_oe_d = ~rd_cur[7];
                            st_d     = iox_pkg::IOX_ST_RDATA;
                        end else begin
                            sda_oe_d = 1'b0;
                            st_d     = iox_pkg::IOX_ST_CMD;
                        end
                    end
                end
                iox_pkg::IOX_ST_CACK: begin
                    if (scl_fall) begin
                        sda_oe_d = 1'b0;
                        st_d     = iox_pkg::IOX_ST_WDATA;
                    end
                end
                iox_pkg::IOX_ST_WACK: begin
                    // commit on the ack clock's rising edge
                    if (scl_rise) begin
                        case (cmd_q[2:1])
                            iox_pkg::IOX_KIND_OUT: lat_d[cmd_q[0]] = sh_q;
                            iox_pkg::IOX_KIND_INV: inv_d[cmd_q[0]] = sh_q;
                            iox_pkg::IOX_KIND_DIR: dir_d[cmd_q[0]] = sh_q;
                            default: ;  // input registers: accepted, no effect
                        endcase
                    end else if (scl_fall) begin
                        // more data goes to the other register of the pair
                        cmd_d[0] = ~cmd_q[0];
                        sda_oe_d = 1'b0;
                        st_d     = iox_pkg::IOX_ST_WDATA;
                    end
                end
                iox_pkg::IOX_ST_RDATA: begin
                    // transmit: master samples on rise, we shift on fall
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == iox_pkg::IOX_BITS_BYTE) begin
                            cnt_d    = '0;
                            sda_oe_d = 1'b0;
                            st_d     = iox_pkg::IOX_ST_RACK;
                        end else begin
                            tx_d     = {tx_q[6:0], 1'b0};
                            sda_oe_d = ~tx_q[6];
                        end
                    end
                end
                iox_pkg::IOX_ST_RACK: begin
                    if (scl_rise) begin
                        mnack_d = sda_s;
                    end else if (scl_fall) begin
                        if (!mnack_q) begin
                            // acked: partner register next, selection follows
                            cmd_d[0] = ~cmd_q[0];
                            tx_d     = rd_next;
                            sda_oe_d = ~rd_next[7];
                            st_d     = iox_pkg::IOX_ST_RDATA;
                        end else begin
                            // nack: release the line and wait for stop
                            sda_oe_d = 1'b0;
                            st_d     = iox_pkg::IOX_ST_IDLE;
                        end
                    end
                end
                default: begin
                    st_d     = iox_pkg::IOX_ST_IDLE;
                    sda_oe_d = 1'b0;
                end
            endcase
        end
        // pin enables follow direction: zero drives, one floats
        poe_d = ~dir_d;
    end

    // registers of the engine and the register file
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            st_q     <= iox_pkg::IOX_ST_IDLE;
            cnt_q    <= '0;
            sh_q     <= '0;
            tx_q     <= '0;
            rw_q     <= 1'b0;
            mnack_q  <= 1'b1;
            sda_oe_q <= 1'b0;
            cmd_q    <= iox_pkg::IOX_CMD_RST;
            lat_q    <= {2{iox_pkg::IOX_OUT_RST}};
            inv_q    <= {2{iox_pkg::IOX_INV_RST}};
            dir_q    <= {2{iox_pkg::IOX_DIR_RST}};
            poe_q    <= {2{~iox_pkg::IOX_DIR_RST}};
        end else begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            sh_q     <= sh_d;
            tx_q     <= tx_d;
            rw_q     <= rw_d;
            mnack_q  <= mnack_d;
            sda_oe_q <= sda_oe_d;
            cmd_q    <= cmd_d;
            lat_q    <= lat_d;
            inv_q    <= inv_d;
            dir_q    <= dir_d;
            poe_q    <= poe_d;
        end
    end

    // outputs straight from flops; open drain only ever pulls low
    assign o_sda            = 1'b0;
    assign o_sda_oe         = sda_oe_q;
    // latch value always presented, enable decides if it reaches the pin
    assign o_port_zero_pins = lat_q[0];
    assign o_port_zero_oe   = poe_q[0];
    assign o_port_one_pins  = lat_q[1];
    assign o_port_one_oe    = poe_q[1];

endmodule

/* File: verif/iox_expander_chk.sv */
/*
 * iox_expander_chk: bus and pin timing checks of the expander top.
 * Assumes it is bound to iox_expander and sees only its ports.
 */
`timescale 1ns/10ps
module iox_expander_chk #(
    parameter int PORT_W = 8
) (
    // clock and reset
    input wire logic              i_mclk,
    input wire logic              i_nrst,
    // straps and bus
    input wire logic              i_addr_strap_low,
    input wire logic              i_addr_strap_high,
    input wire logic              i_scl,
    input wire logic              i_sda,
    input wire logic              o_sda,
    input wire logic              o_sda_oe,
    // port pins
    input wire logic [PORT_W-1:0] i_port_zero_pins,
    input wire logic [PORT_W-1:0] o_port_zero_pins,
    input wire logic [PORT_W-1:0] o_port_zero_oe,
    input wire logic [PORT_W-1:0] i_port_one_pins,
    input wire logic [PORT_W-1:0] o_port_one_pins,
    input wire logic [PORT_W-1:0] o_port_one_oe
);
    // one domain: every check rests while reset is low
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    a_rst_dir_in: assert property ($rose(i_nrst) |->
        (o_port_zero_oe == 8'h00) && (o_port_one_oe == 8'h00))
        else $error("pin enables not cleared by reset");
    a_rst_latch_ones: assert property ($rose(i_nrst) |->
        (o_port_zero_pins == 8'hff) && (o_port_one_pins == 8'hff))
        else $error("output latches not all ones after reset");
    a_rst_bus_idle: assert property ($rose(i_nrst) |-> !o_sda_oe)
        else $error("data line pulled right after reset");
    // data may only move while the bus clock is low
    a_oe_steady: assert property (i_scl |-> $stable(o_sda_oe))
        else $error("data line changed while bus clock high");
    a_ack_hold: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
        else $error("acknowledge pulse too short");
    a_bus_release: assert property ($fell(o_sda_oe) |-> !i_scl)
        else $error("data line released while bus clock high");
    a_sda_open_drain: assert property (o_sda == 1'b0)
        else $error("data output value not low");
    // commits land inside the high phase of the acknowledge clock
    a_latch_commit: assert property ($changed(o_port_zero_pins) ||
        $changed(o_port_one_pins) |-> i_scl)
        else $error("latch changed outside acknowledge clock");
    a_dir_commit: assert property ($changed(o_port_zero_oe) ||
        $changed(o_port_one_oe) |-> i_scl)
        else $error("pin enable changed outside acknowledge clock");

    c_ack: cover property ($rose(o_sda_oe));
    c_latch: cover property ($changed(o_port_zero_pins));
    c_dir: cover property ($changed(o_port_zero_oe));
endmodule

bind iox_expander iox_expander_chk #(.PORT_W(PORT_W)) u_iox_expander_chk (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr_strap_low(i_addr_strap_low),
    .i_addr_strap_high(i_addr_strap_high), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_port_zero_pins(i_port_zero_pins),
    .o_port_zero_pins(o_port_zero_pins), .o_port_zero_oe(o_port_zero_oe),
    .i_port_one_pins(i_port_one_pins), .o_port_one_pins(o_port_one_pins),
    .o_port_one_oe(o_port_one_oe)
);

/* File: verif/iox_mst.sv */
/*
 * iox_mst: behavioural two-wire bus master, 125 ns bit period.
 * Assumes the data line is resolved outside with a pull-up; the bus
 * clock stands high between frames.
 */
`timescale 1ns/10ps
module iox_mst (
    // resolved data line
    input  wire logic i_sda,
    // bus clock and data pull-down
    output logic      o_scl,
    output logic      o_sda_pull
);
    localparam realtime QTR = 31.25; // quarter of the bit period

    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    // data set in mid-low, sampled in mid-high
    task automatic bit_xfer(input logic b, output logic r);
        #QTR o_sda_pull = ~b;
        #QTR o_scl = 1'b1;
        #QTR r = i_sda;
        #QTR o_scl = 1'b0;
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        #QTR o_sda_pull = 1'b0;
        #QTR o_scl = 1'b1;
        #QTR o_sda_pull = 1'b1;
        #QTR o_scl = 1'b0;
    endtask
    // stop: data rises while clock high, clock then stands
    task automatic stop();
        #QTR o_sda_pull = 1'b1;
        #QTR o_scl = 1'b1;
        #QTR o_sda_pull = 1'b0;
        #QTR;
    endtask
    // send a byte msb first, return the slave acknowledge
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], r);
        end
        bit_xfer(1'b1, r);
        ack = (r === 1'b0);
    endtask
    // receive a byte; the last one is not acknowledged
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, b[i]);
        end
        bit_xfer(last, r);
    endtask
endmodule

/* File: verif/iox_expander_tb.sv */
/*
 * iox_expander_tb: register and bus tests of the expander through the
 * master model. Assumes a pull-up on the data line and port pins that
 * resolve from the enables against an external level.
 */
`timescale 1ns/10ps
module iox_expander_tb;
    logic       i_mclk = 1'b0;  // system clock
    logic       i_nrst = 1'b0;  // active-low reset
    logic [1:0] strap  = 2'h0;  // {high, low} straps
    logic [7:0] ext0   = 8'h3c; // level outside port zero
    logic [7:0] ext1   = 8'hc5; // level outside port one
    logic       scl, m_pull, o_sda, o_sda_oe, sda_w, mk;
    logic [7:0] o_p0, o_p0_oe, o_p1, o_p1_oe, i_p0, i_p1;
    logic [6:0] dev;
    int         error_cnt = 0;
    int         num_checks = 0;

    always #2 i_mclk = ~i_mclk;
    // open-drain data line with pull-up; pins follow whoever drives
    assign sda_w = o_sda_oe ? o_sda : ~m_pull;
    assign i_p0 = (o_p0_oe & o_p0) | (~o_p0_oe & ext0);
    assign i_p1 = (o_p1_oe & o_p1) | (~o_p1_oe & ext1);
    assign dev = {5'h1d, strap};

    iox_expander u_iox_expander (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr_strap_low(strap[0]),
        .i_addr_strap_high(strap[1]), .i_scl(scl), .i_sda(sda_w), .o_sda(o_sda),
        .o_sda_oe(o_sda_oe), .i_port_zero_pins(i_p0), .o_port_zero_pins(o_p0),
        .o_port_zero_oe(o_p0_oe), .i_port_one_pins(i_p1), .o_port_one_pins(o_p1),
        .o_port_one_oe(o_p1_oe)
    );
    iox_mst u_iox_mst (.i_sda(sda_w), .o_scl(scl), .o_sda_pull(m_pull));

    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // full write; a foreign address must leave the address and command bytes unanswered
    task automatic wr(input logic [6:0] a, input logic [7:0] c, d0, d1);
        logic k;
        u_iox_mst.start();
        u_iox_mst.wbyte({a, 1'b0}, k);
        check("addr ack", {7'h00, a == dev}, {7'h00, k});
        u_iox_mst.wbyte(c, k);
        check("cmd ack", {7'h00, a == dev}, {7'h00, k});
        u_iox_mst.wbyte(d0, k);
        u_iox_mst.wbyte(d1, k);
        u_iox_mst.stop();
    endtask
    // two-byte read, optionally after setting the command
    task automatic rd(input logic set, input logic [7:0] c, e0, e1);
        logic k;
        logic [7:0] v;
        if (set) begin
            u_iox_mst.start();
            u_iox_mst.wbyte({dev, 1'b0}, k);
            u_iox_mst.wbyte(c, k);
        end
        u_iox_mst.start();
        u_iox_mst.wbyte({dev, 1'b1}, k);
        u_iox_mst.rbyte(1'b0, v);
        check($sformatf("reg %h first", c), e0, v);
        u_iox_mst.rbyte(1'b1, v);
        check($sformatf("reg %h second", c), e1, v);
        u_iox_mst.stop();
    endtask

    initial begin
        repeat (5) @(posedge i_mclk);
        #1 i_nrst = 1'b1;
        repeat (8) @(posedge i_mclk);
        rd(1'b1, 8'h02, 8'hff, 8'hff);
        rd(1'b1, 8'h04, 8'h00, 8'h00);
        rd(1'b1, 8'h06, 8'hff, 8'hff);
        rd(1'b1, 8'h00, 8'h3c, 8'hc5);
        check("oe idle", 8'h00, o_p0_oe | o_p1_oe);
        $display("test defaults done");
        // port zero driven, port one left as input
        wr(dev, 8'h02, 8'h5a, 8'h96);
        wr(dev, 8'h04, 8'hf0, 8'h0f);
        wr(dev, 8'h06, 8'h00, 8'hff);
        rd(1'b1, 8'h02, 8'h5a, 8'h96);
        rd(1'b1, 8'h05, 8'h0f, 8'hf0);
        rd(1'b1, 8'h06, 8'h00, 8'hff);
        check("p0 oe", 8'hff, o_p0_oe);
        check("p1 oe", 8'h00, o_p1_oe);
        check("p0 out", 8'h5a, o_p0);
        check("p1 out", 8'h96, o_p1);
        rd(1'b1, 8'h00, 8'haa, 8'hca);
        rd(1'b0, 8'h01, 8'hca, 8'haa);
        // input registers take the write but keep the output, inversion and direction registers
        wr(dev, 8'h01, 8'h00, 8'h00);
        rd(1'b1, 8'h02, 8'h5a, 8'h96);
        rd(1'b1, 8'h04, 8'hf0, 8'h0f);
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            @(posedge i_mclk);
            #1 strap = s[1:0];
            repeat (8) @(posedge i_mclk);
            wr(dev ^ (7'h01 << s), 8'h02, 8'h11, 8'h22);
            wr(dev, 8'h02, {6'h00, s[1:0]}, 8'h33);
            rd(1'b1, 8'h02, {6'h00, s[1:0]}, 8'h33);
        end
        $display("test address done");
        // reset lands in mid-frame; the engine must come back idle
        u_iox_mst.start();
        u_iox_mst.wbyte({dev, 1'b0}, mk);
        check("rst addr ack", 8'h01, {7'h00, mk});
        @(posedge i_mclk);
        #1 i_nrst = 1'b0;
        repeat (3) @(posedge i_mclk);
        #1 i_nrst = 1'b1;
        u_iox_mst.stop();
        rd(1'b1, 8'h02, 8'hff, 8'hff);
        rd(1'b1, 8'h04, 8'h00, 8'h00);
        rd(1'b1, 8'h06, 8'hff, 8'hff);
        $display("test reset done");
        tally_and_finish();
    end
    // watchdog, well beyond the roughly 164 us the tests need
    initial begin
        #300000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
